// ===== logic/pws_timer_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pws_defs.vh"

module pws_timer_top (
    // clock and reset
    input wire clock,
    input wire rst,
    // register access
    input wire regWrEn,
    input wire regWide,
    input wire regRdEn,
    input wire [5:0] regAddr,
    input wire [15:0] regWrData,
    input wire [15:0] regWrDataLow,
    output reg [15:0] regRdData,
    // prescaled base tick into the counter prescalers
    input wire pclk1Tick,
    // bus interface config
    input wire [2:0] biuArbBits,
    input wire [1:0] vectorHighBits,
    // interrupt arbitration
    input wire arbStart,
    input wire [2:0] arbLevel,
    output wire arbRespond,
    output wire [3:0] arbPriority,
    output wire [7:0] arbVector,
    output wire [6:0] irqLines,
    // output pins
    output reg [3:0] pwmPin
);

// ----------------------------------------
// per-unit state
// ----------------------------------------
reg [15:0] count_r [0:3];
reg [15:0] nextPeriod_r [0:3];
reg [15:0] nextWidth_r [0:3];
reg [15:0] activePeriod_r [0:3];
reg [15:0] activeWidth_r [0:3];
reg [2:0] clkSel_r [0:3];
reg [2:0] level_r [0:3];
reg [3:0] outFf_r;
reg [3:0] flag_r;
reg [3:0] enable_r;
reg [3:0] polarity_r;
reg [3:0] arbLow_r;

wire [3:0] tick;
wire [3:0] pending;
wire [11:0] levelBus;

// ----------------------------------------
// address decode
// ----------------------------------------
wire [3:0] unitNum = regAddr[5:2];
wire [1:0] wordSel = regAddr[1:0];
wire unitHit = (unitNum >= `PWS_FIRST_UNIT) && (unitNum <= `PWS_LAST_UNIT);
wire [1:0] unitIdx = unitNum[1:0] - 2'h1;

reg [3:0] wrCtrl;
reg [3:0] wrPeriod;
reg [3:0] wrWidth;
reg [3:0] loadNow;
reg [3:0] wrAny;
integer k;

always @* begin
    wrCtrl = 4'h0;
    wrPeriod = 4'h0;
    wrWidth = 4'h0;
    loadNow = 4'h0;
    wrAny = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
        if (regWrEn && unitHit && unitIdx == k[1:0]) begin
            if (regWide && wordSel == `PWS_W_PERIOD) begin
                wrPeriod[k] = 1'b1;
                wrWidth[k] = 1'b1;
            end else if (wordSel == `PWS_W_CTRL) begin
                wrCtrl[k] = 1'b1;
                loadNow[k] = regWrData[`PWS_F_LOAD];
            end else if (wordSel == `PWS_W_PERIOD) begin
                wrPeriod[k] = 1'b1;
            end else if (wordSel == `PWS_W_WIDTH) begin
                wrWidth[k] = 1'b1;
            end
            wrAny[k] = wrPeriod[k] || wrWidth[k];
        end
    end
end

// ----------------------------------------
// prescalers, one per unit
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : preGen
        pws_prescaler prescaler (
            .clock(clock),
            .rst(rst),
            .run(enable_r[g]),
            .pclk1Tick(pclk1Tick),
            .clkSel(clkSel_r[g]),
            .counterTick(tick[g])
        );
        assign pending[g] = flag_r[g] && (level_r[g] != 3'h0);
        assign levelBus[3*g +: 3] = level_r[g];
    end
endgenerate

// ----------------------------------------
// period and duty comparators
// ----------------------------------------
reg [3:0] periodMatch;
reg [3:0] zeroDuty;
reg [3:0] fullDuty;
reg [16:0] effPeriod;
integer m;

always @* begin
    periodMatch = 4'h0;
    zeroDuty = 4'h0;
    fullDuty = 4'h0;
    effPeriod = 17'h00000;
    for (m = 0; m < 4; m = m + 1) begin
        // period value zero stands for 65536 counter ticks
        effPeriod = (activePeriod_r[m] == 16'h0000) ? `PWS_FULL_SPAN :
            {1'b0, activePeriod_r[m]};
        periodMatch[m] = (count_r[m] == activePeriod_r[m]);
        zeroDuty[m] = (activeWidth_r[m] == 16'h0000);
        fullDuty[m] = ({1'b0, activeWidth_r[m]} >= effPeriod);
    end
end

// ----------------------------------------
// software-visible configuration
// ----------------------------------------
integer c;

always @(posedge clock) begin
    if (rst) begin
        for (c = 0; c < 4; c = c + 1) begin
            nextPeriod_r[c] <= `PWS_RST_PERIOD;
            nextWidth_r[c] <= `PWS_RST_WIDTH;
            clkSel_r[c] <= `PWS_RST_CLK;
            level_r[c] <= `PWS_RST_LVL;
        end
        enable_r <= 4'h0;
        polarity_r <= 4'h0;
        arbLow_r <= 4'h0;
    end else begin
        for (c = 0; c < 4; c = c + 1) begin
            // control word; reserved bits dropped
            if (wrCtrl[c]) begin
                enable_r[c] <= regWrData[`PWS_F_EN];
                polarity_r[c] <= regWrData[`PWS_F_POL];
                arbLow_r[c] <= regWrData[`PWS_F_ARBLOW];
                clkSel_r[c] <= regWrData[`PWS_F_CLK_HI:`PWS_F_CLK_LO];
                level_r[c] <= regWrData[`PWS_F_LVL_HI:`PWS_F_LVL_LO];
            end
            // next values, picked up at the period edge
            if (wrPeriod[c]) begin
                nextPeriod_r[c] <= regWrData;
            end
            if (wrWidth[c]) begin
                nextWidth_r[c] <= regWide ? regWrDataLow : regWrData;
            end
        end
    end
end

// ----------------------------------------
// period flag
// ----------------------------------------
integer f;

always @(posedge clock) begin
    if (rst) begin
        flag_r <= 4'h0;
    end else begin
        for (f = 0; f < 4; f = f + 1) begin
            // new period sets, writing zero clears, set wins
            // a disabled unit never sets, so a clear then sticks
            if (enable_r[f] && tick[f] && periodMatch[f]) begin
                flag_r[f] <= 1'b1;
            end else if (wrCtrl[f] && !regWrData[`PWS_F_FLAG]) begin
                flag_r[f] <= 1'b0;
            end
        end
    end
end

// ----------------------------------------
// counter and output flip-flop sequencer
// ----------------------------------------
integer i;

always @(posedge clock) begin
    if (rst) begin
        // counter rests at one out of reset
        for (i = 0; i < 4; i = i + 1) begin
            count_r[i] <= `PWS_RST_COUNT;
            activePeriod_r[i] <= `PWS_RST_PERIOD;
            activeWidth_r[i] <= `PWS_RST_WIDTH;
        end
        outFf_r <= 4'h0;
    end else begin
        for (i = 0; i < 4; i = i + 1) begin
            if (!enable_r[i]) begin
                count_r[i] <= `PWS_RST_COUNT;
                outFf_r[i] <= 1'b0;
                if (loadNow[i]) begin
                    activePeriod_r[i] <= nextPeriod_r[i];
                    activeWidth_r[i] <= nextWidth_r[i];
                end
            end else if (tick[i] && periodMatch[i]) begin
                // counter runs regardless of duty
                count_r[i] <= `PWS_RST_COUNT;
                outFf_r[i] <= !zeroDuty[i];
                // a write at the period edge defers the transfer
                if (!wrAny[i] || loadNow[i]) begin
                    activePeriod_r[i] <= nextPeriod_r[i];
                    activeWidth_r[i] <= nextWidth_r[i];
                end
            end else begin
                if (tick[i]) begin
                    count_r[i] <= count_r[i] + 16'h0001;
                end
                if (tick[i] && count_r[i] == activeWidth_r[i] &&
                    !fullDuty[i]) begin
                    outFf_r[i] <= 1'b0;
                end else if (fullDuty[i]) begin
                    outFf_r[i] <= 1'b1;
                end else if (zeroDuty[i]) begin
                    outFf_r[i] <= 1'b0;
                end
                if (loadNow[i]) begin
                    activePeriod_r[i] <= nextPeriod_r[i];
                    activeWidth_r[i] <= nextWidth_r[i];
                end
            end
        end
    end
end

// ----------------------------------------
// pin drive
// ----------------------------------------
integer p;

always @(posedge clock) begin
    if (rst) begin
        pwmPin <= 4'h0;
    end else begin
        for (p = 0; p < 4; p = p + 1) begin
            if (!enable_r[p]) begin
                // idle pin is a plain output of the polarity bit
                pwmPin[p] <= polarity_r[p];
            end else begin
                // polarity one is active high
                pwmPin[p] <= outFf_r[p] ~^ polarity_r[p];
            end
        end
    end
end

// ----------------------------------------
// read path
// ----------------------------------------
reg [15:0] rdNxt;

always @* begin
    rdNxt = 16'h0000;
    if (!unitHit) begin
        rdNxt = 16'h0000;
    end else if (wordSel == `PWS_W_CTRL) begin
        rdNxt[`PWS_F_FLAG] = flag_r[unitIdx];
        rdNxt[`PWS_F_ARBLOW] = arbLow_r[unitIdx];
        rdNxt[`PWS_F_LVL_HI:`PWS_F_LVL_LO] = level_r[unitIdx];
        rdNxt[`PWS_F_POL] = polarity_r[unitIdx];
        rdNxt[`PWS_F_PIN] = pwmPin[unitIdx];
        rdNxt[`PWS_F_EN] = enable_r[unitIdx];
        rdNxt[`PWS_F_CLK_HI:`PWS_F_CLK_LO] = clkSel_r[unitIdx];
    end else if (wordSel == `PWS_W_PERIOD) begin
        rdNxt = nextPeriod_r[unitIdx];
    end else if (wordSel == `PWS_W_WIDTH) begin
        rdNxt = nextWidth_r[unitIdx];
    end else begin
        rdNxt = count_r[unitIdx];
    end
end

always @(posedge clock) begin
    if (rst) begin
        regRdData <= 16'h0000;
    end else if (regRdEn) begin
        regRdData <= rdNxt;
    end
end

// ----------------------------------------
// interrupt request and arbitration
// ----------------------------------------
pws_irq_arb arbiter (
    .clock(clock),
    .rst(rst),
    .pending(pending),
    .levels(levelBus),
    .arbLowBits(arbLow_r),
    .biuArbBits(biuArbBits),
    .vectorHighBits(vectorHighBits),
    .arbStart(arbStart),
    .arbLevel(arbLevel),
    .arbRespond(arbRespond),
    .arbPriority(arbPriority),
    .arbVector(arbVector),
    .irqLines(irqLines)
);

endmodule
`default_nettype wire

// ===== logic/pws_defs.vh
`ifndef PWS_DEFS_VH
`define PWS_DEFS_VH

// ----------------------------------------
// unit numbering and vectors
// ----------------------------------------
`define PWS_UNITS 4
`define PWS_FIRST_UNIT 4'h5
`define PWS_LAST_UNIT 4'h8

// ----------------------------------------
// word index inside one unit window
// ----------------------------------------
`define PWS_W_CTRL 2'h0
`define PWS_W_PERIOD 2'h1
`define PWS_W_WIDTH 2'h2
`define PWS_W_COUNT 2'h3

// ----------------------------------------
// control word field positions
// ----------------------------------------
`define PWS_F_FLAG 15
`define PWS_F_ARBLOW 14
`define PWS_F_LVL_HI 10
`define PWS_F_LVL_LO 8
`define PWS_F_LOAD 6
`define PWS_F_POL 5
`define PWS_F_PIN 4
`define PWS_F_EN 3
`define PWS_F_CLK_HI 2
`define PWS_F_CLK_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PWS_RST_COUNT 16'h0001
`define PWS_RST_PERIOD 16'h0000
`define PWS_RST_WIDTH 16'h0000
`define PWS_RST_CLK 3'h0
`define PWS_RST_LVL 3'h0
`define PWS_RST_PRE 8'h00

// ----------------------------------------
// prescaler ratios
// ----------------------------------------
`define PWS_PRE_MAX_SEL 3'h7
`define PWS_PRE_FULL 8'hff

// ----------------------------------------
// timing counts
// ----------------------------------------
`define PWS_FULL_SPAN 17'h10000

`endif

// ===== logic/pws_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "pws_defs.vh"

module pws_prescaler (
    // clock and reset
    input wire clock,
    input wire rst,
    // control
    input wire run,
    input wire pclk1Tick,
    input wire [2:0] clkSel,
    // counter clock
    output wire counterTick
);

reg [7:0] preCount_r;
reg [7:0] mask;

// ----------------------------------------
// divide-by 1..64 and 256 of the base tick
// ----------------------------------------
always @* begin
    if (clkSel == `PWS_PRE_MAX_SEL) begin
        mask = `PWS_PRE_FULL;
    end else begin
        mask = (8'h01 << clkSel) - 8'h01;
    end
end

always @(posedge clock) begin
    if (rst || !run) begin
        preCount_r <= `PWS_RST_PRE;
    end else if (pclk1Tick) begin
        preCount_r <= preCount_r + 8'h01;
    end
end

assign counterTick = run && pclk1Tick && ((preCount_r & mask) == mask);

endmodule
`default_nettype wire

// ===== logic/pws_irq_arb.v
`timescale 1ns/1ps
`default_nettype none
`include "pws_defs.vh"

module pws_irq_arb (
    // clock and reset
    input wire clock,
    input wire rst,
    // unit requests
    input wire [3:0] pending,
    input wire [11:0] levels,
    input wire [3:0] arbLowBits,
    // bus interface config
    input wire [2:0] biuArbBits,
    input wire [1:0] vectorHighBits,
    // arbitration cycle
    input wire arbStart,
    input wire [2:0] arbLevel,
    output reg arbRespond,
    output reg [3:0] arbPriority,
    output reg [7:0] arbVector,
    // request lines, bit n is level n+1
    output reg [6:0] irqLines
);

reg [6:0] lineNxt;
reg [3:0] hit;
reg found;
reg [1:0] winner;
integer i;

// ----------------------------------------
// level decode and fixed priority pick
// ----------------------------------------
always @* begin
    lineNxt = 7'h00;
    hit = 4'h0;
    found = 1'b0;
    winner = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
        if (pending[i] && levels[3*i +: 3] != 3'h0) begin
            lineNxt[levels[3*i +: 3] - 3'h1] = 1'b1;
            hit[i] = (levels[3*i +: 3] == arbLevel);
        end
    end
    for (i = 3; i >= 0; i = i - 1) begin
        if (hit[i]) begin
            found = 1'b1;
            winner = i[1:0];
        end
    end
end

always @(posedge clock) begin
    if (rst) begin
        irqLines <= 7'h00;
        arbRespond <= 1'b0;
        arbPriority <= 4'h0;
        arbVector <= 8'h00;
    end else begin
        irqLines <= lineNxt;
        arbRespond <= arbStart && found;
        if (arbStart && found) begin
            arbPriority <= {arbLowBits[winner], biuArbBits};
            arbVector <= {vectorHighBits,
                2'h0, `PWS_FIRST_UNIT + {2'h0, winner}};
        end
    end
end

endmodule
`default_nettype wire

// ===== verif/pws_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pws_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // upstream divide select
    input wire logic div3,
    // base tick
    output var logic pclk1Tick
);
    logic [1:0] cnt;
    initial begin
        cnt = 2'h0;
        pclk1Tick = 1'b0;
    end
    // one tick every 2 or 3 system clocks
    always @(negedge clock) begin
        pclk1Tick <= !rst && cnt == 2'h0;
        if (rst || cnt == (div3 ? 2'h2 : 2'h1)) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== verif/pws_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pws_timer_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register access
    input wire logic regRdEn,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regRdData,
    // arbitration
    input wire logic [2:0] biuArbBits,
    input wire logic [1:0] vectorHighBits,
    input wire logic arbStart,
    input wire logic [2:0] arbLevel,
    input wire logic arbRespond,
    input wire logic [3:0] arbPriority,
    input wire logic [7:0] arbVector,
    input wire logic [6:0] irqLines,
    input wire logic [3:0] pwmPin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ----
    // sequences and properties
    // ----
    sequence s_arb;
        arbStart ##1 arbRespond;
    endsequence
    property p_rdUnmap;
        regRdEn && (regAddr[5:2] < 4'h5 || regAddr[5:2] > 4'h8)
            |=> regRdData == 16'h0000;
    endproperty
    property p_rdResv;
        regRdEn && regAddr[1:0] == 2'h0 |=> (regRdData & 16'h38c0) == 0;
    endproperty
    property p_vecUnit;
        arbRespond |-> arbVector[5:0] >= 6'h05 && arbVector[5:0] <= 6'h08;
    endproperty
    property p_vecHigh;
        s_arb |-> arbVector[7:6] == $past(vectorHighBits);
    endproperty
    property p_priLow;
        s_arb |-> arbPriority[2:0] == $past(biuArbBits);
    endproperty
    property p_lvlZero;
        arbStart && arbLevel == 3'h0 |=> !arbRespond;
    endproperty
    property p_respCause;
        arbRespond |-> $past(arbStart);
    endproperty
    property p_rstOut;
        disable iff (1'b0)
        rst |=> pwmPin == 4'h0 && irqLines == 7'h00 && !arbRespond;
    endproperty
    a_rdUnmap: assert property (p_rdUnmap)
        else $error("unmapped read not zero");
    a_rdResv: assert property (p_rdResv)
        else $error("reserved control bits not zero");
    a_vecUnit: assert property (p_vecUnit)
        else $error("vector unit number out of range");
    a_vecHigh: assert property (p_vecHigh)
        else $error("vector high bits wrong");
    a_priLow: assert property (p_priLow)
        else $error("priority low bits wrong");
    a_lvlZero: assert property (p_lvlZero)
        else $error("answer at level zero");
    a_respCause: assert property (p_respCause)
        else $error("answer without arbitration");
    a_rstOut: assert property (p_rstOut)
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ===== verif/pws_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pws_timer_tb_top;
    logic clock, rst, regWrEn, regWide, regRdEn, pclk1Tick, div3;
    logic arbStart, arbRespond;
    logic [5:0] regAddr;
    logic [15:0] regWrData, regWrDataLow, regRdData, d;
    logic [2:0] biuArbBits, arbLevel;
    logic [1:0] vectorHighBits;
    logic [3:0] arbPriority, pwmPin;
    logic [7:0] arbVector;
    logic [6:0] irqLines;
    int failures, compares, hi, per;
    pws_timer_top dut (.clock(clock), .rst(rst), .regWrEn(regWrEn),
        .regWide(regWide), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrDataLow(regWrDataLow),
        .regRdData(regRdData), .pclk1Tick(pclk1Tick),
        .biuArbBits(biuArbBits), .vectorHighBits(vectorHighBits),
        .arbStart(arbStart), .arbLevel(arbLevel), .arbRespond(arbRespond),
        .arbPriority(arbPriority), .arbVector(arbVector),
        .irqLines(irqLines), .pwmPin(pwmPin));
    pws_host_model host (.clock(clock), .rst(rst), .div3(div3),
        .pclk1Tick(pclk1Tick));
    always #25 clock = ~clock;
    // ----
    // shared tasks
    // ----
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task wr(input logic [5:0] a, input logic [15:0] v, w, input logic wd);
        @(negedge clock);
        regWrEn = 1'b1;
        regWide = wd;
        regAddr = a;
        regWrData = v;
        regWrDataLow = w;
        @(negedge clock);
        regWrEn = 1'b0;
        regWide = 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(negedge clock);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clock);
        regRdEn = 1'b0;
        d = regRdData;
    endtask
    task cfg(input logic [3:0] u, input logic [15:0] p, w, c);
        wr({u, 2'h1}, p, w, 1'b1);
        wr({u, 2'h0}, c | 16'h0040, 16'h0000, 1'b0);
    endtask
    task measure(input int i);
        int n;
        n = 0;
        hi = 0;
        while (pwmPin[i] !== 1'b0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        while (pwmPin[i] !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        while (pwmPin[i] === 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
            hi++;
        end
        per = hi;
        while (pwmPin[i] !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
            per++;
        end
    endtask
    task steady(input int i, input logic v, output int bad);
        bad = 0;
        // pin trails the active values by two edges
        repeat (2) @(negedge clock);
        repeat (40) begin
            @(negedge clock);
            if (pwmPin[i] !== v) bad++;
        end
    endtask
    task arb(input logic [2:0] l, input logic r, input logic [7:0] v);
        @(negedge clock);
        arbStart = 1'b1;
        arbLevel = l;
        @(negedge clock);
        arbStart = 1'b0;
        check(arbRespond, r);
        if (r) check(arbVector, v);
    endtask
    // ----
    // scenarios
    // ----
    task t_regs;
        rd(6'h17);
        check(d, 16'h0001);
        wr(6'h17, 16'h1234, 16'h0000, 1'b0);
        rd(6'h17);
        check(d, 16'h0001);
        wr(6'h24, 16'h1234, 16'h0000, 1'b0);
        rd(6'h24);
        check(d, 16'h0000);
        wr(6'h18, 16'hffff, 16'h0000, 1'b0);
        rd(6'h18);
        check(d, 16'h472f);
        wr(6'h18, 16'h0000, 16'h0000, 1'b0);
        $display("test regs done");
    endtask
    task t_pwm;
        int bad;
        cfg(4'h5, 16'h0004, 16'h0001, 16'h0028);
        measure(0);
        check(hi, 2);
        check(per, 8);
        wr(6'h15, 16'h0004, 16'h0003, 1'b1);
        measure(0);
        measure(0);
        check(hi, 6);
        check(per, 8);
        cfg(4'h5, 16'h0004, 16'h0000, 16'h0028);
        steady(0, 1'b0, bad);
        check(bad, 0);
        rd(6'h14);
        check(d[15], 1'b1);
        cfg(4'h5, 16'h0004, 16'h0005, 16'h0028);
        steady(0, 1'b1, bad);
        check(bad, 0);
        cfg(4'h5, 16'h0004, 16'h0004, 16'h0008);
        steady(0, 1'b0, bad);
        check(bad, 0);
        cfg(4'h5, 16'h0004, 16'h0000, 16'h0008);
        steady(0, 1'b1, bad);
        check(bad, 0);
        cfg(4'h5, 16'h0004, 16'h0001, 16'h0029);
        measure(0);
        check(per, 16);
        div3 = 1'b1;
        cfg(4'h5, 16'h0004, 16'h0001, 16'h0028);
        measure(0);
        check(per, 12);
        div3 = 1'b0;
        $display("test pwm done");
    endtask
    task t_irq;
        cfg(4'h6, 16'h0002, 16'h0001, 16'h4328);
        cfg(4'h7, 16'h0002, 16'h0001, 16'h0328);
        cfg(4'h8, 16'h0002, 16'h0001, 16'h0528);
        repeat (20) @(negedge clock);
        check(irqLines, 7'h14);
        arb(3'h3, 1'b1, 8'h86);
        check(arbPriority, 4'hd);
        // second write clears once the unit has stopped
        wr(6'h18, 16'h0300, 16'h0000, 1'b0);
        wr(6'h18, 16'h0300, 16'h0000, 1'b0);
        arb(3'h3, 1'b1, 8'h87);
        check(arbPriority, 4'h5);
        arb(3'h5, 1'b1, 8'h88);
        arb(3'h2, 1'b0, 8'h00);
        arb(3'h0, 1'b0, 8'h00);
        $display("test irq done");
    endtask
    initial begin
        #1000000;
        failures++;
        conclude;
    end
    initial begin
        clock = 0;
        rst = 1;
        {regWrEn, regWide, regRdEn, arbStart, div3} = 0;
        {regAddr, regWrData, regWrDataLow, arbLevel} = 0;
        biuArbBits = 3'h5;
        vectorHighBits = 2'h2;
        failures = 0;
        compares = 0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 0;
        t_regs;
        t_pwm;
        t_irq;
        conclude;
    end
endmodule
bind pws_timer_top pws_timer_chk chk (.clock(clock), .rst(rst),
    .regRdEn(regRdEn), .regAddr(regAddr), .regRdData(regRdData),
    .biuArbBits(biuArbBits), .vectorHighBits(vectorHighBits),
    .arbStart(arbStart), .arbLevel(arbLevel), .arbRespond(arbRespond),
    .arbPriority(arbPriority), .arbVector(arbVector),
    .irqLines(irqLines), .pwmPin(pwmPin));
`default_nettype wire
